// file: design/ras_cfg.svh
// Constants of the return address stack: offsets, fields, resets, vectors.
// Assumes inclusion by bare name from the package and the top module.
`ifndef RAS_CFG_SVH
`define RAS_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define RAS_PC_W        21
`define RAS_SP_W        5
`define RAS_AXI_AW      8
`define RAS_IMPL_BYTES  32768
`define RAS_WORD_W      16

// ----------------------------------------------------------------
// Register byte offsets on the AXI4-Lite port
// ----------------------------------------------------------------
`define RAS_OFS_PTR     8'h00
`define RAS_OFS_TOP_LO  8'h04
`define RAS_OFS_TOP_HI  8'h08
`define RAS_OFS_TOP_UP  8'h0c

// ----------------------------------------------------------------
// Pointer register fields and reset values
// ----------------------------------------------------------------
`define RAS_BIT_FULL    7
`define RAS_BIT_UNF     6
`define RAS_PTR_RST     8'h00
`define RAS_SP_RST      5'h00

// ----------------------------------------------------------------
// Vectors, program counter step, bus responses
// ----------------------------------------------------------------
`define RAS_VEC_RESET   21'h000000
`define RAS_VEC_A       21'h000008
`define RAS_VEC_B       21'h000018
`define RAS_PC_STEP     21'h000002
`define RAS_RESP_OKAY   2'b00
`define RAS_RESP_SLVERR 2'b10

`endif

// file: design/ras_pkg.sv
// Types shared by the return address stack.
// Assumes ras_cfg.svh is on the include path.
`include "ras_cfg.svh"

package ras_pkg;

	// ----------------------------------------------------------------
	// Register selection
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ras_reg_none,
		ras_reg_ptr,
		ras_reg_lo,
		ras_reg_hi,
		ras_reg_up
	} ras_reg_t;

	// Pointer register layout
	typedef struct packed {
		logic                 full;   // Stack full flag
		logic                 unf;    // Stack underflow flag
		logic                 rsv;    // Reads zero
		logic [`RAS_SP_W-1:0] sp;     // Pointer value bits
	} ras_ptr_t;

	// Request from the instruction sequencer, one cycle each
	typedef struct packed {
		logic                 push;    // Push, call, relative call
		logic                 pop;     // Any return type
		logic                 int_ack; // Interrupt acknowledge
		logic                 int_sel; // 0: vector 0008h, 1: 0018h
		logic [`RAS_PC_W-1:0] pc;      // Program counter to save
	} ras_core_req_t;

endpackage : ras_pkg

// file: design/ras_top.sv
// Return address stack with AXI4-Lite access and program fetch gating.
// Assumes core requests and sys_rst come from logic on clk, one pulse
// per operation, and that ovf_rst_en is a static configuration level.
//
// What this block does
// - Program counter is 21 bits wide
// - Reset vector 0000h, interrupts 0008h or 0018h
// - Fetches beyond implemented memory return zero
// - Program fetch port separate from register bus
// - Push on push, calls, interrupt acknowledge
// - Pop on all returns, latches untouched
// - 31 entries, 5-bit pointer, reset clears
// - Push: increment pointer, then write entry
// - Pop: read entry, then decrement pointer
// - Stack reachable only through its registers
// - Top entry bytes and pointer software accessible
// - Full flag after 31 pushes, sticky
// - Overflow reset: store pc plus two, reset
// - No overflow reset: pointer holds, overwrite
// - Pop at zero: load zero, set underflow
// - Underflow also resets when enabled
`timescale 1ns/100ps
`include "ras_cfg.svh"

module ras_top
	import ras_pkg::*;
#(
	parameter int DEPTH      = 31,
	parameter int IMPL_BYTES = `RAS_IMPL_BYTES
) (
	clk,
	arst_n,
	sys_rst,
	ovf_rst_en,
	core_req,
	pc_load_valid,
	pc_load,
	dev_reset_req,
	fetch_req,
	fetch_addr,
	mem_addr,
	mem_rdata,
	fetch_valid,
	fetch_data,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready
);
	localparam int MA_W = $clog2(IMPL_BYTES);

	input  wire logic                   clk;
	input  wire logic                   arst_n;
	input  wire logic                   sys_rst;
	input  wire logic                   ovf_rst_en;
	input  wire ras_core_req_t          core_req;
	output logic                        pc_load_valid;
	output logic [`RAS_PC_W-1:0]        pc_load;
	output logic                        dev_reset_req;
	input  wire logic                   fetch_req;
	input  wire logic [`RAS_PC_W-1:0]   fetch_addr;
	output logic [MA_W-1:0]             mem_addr;
	input  wire logic [`RAS_WORD_W-1:0] mem_rdata;
	output logic                        fetch_valid;
	output logic [`RAS_WORD_W-1:0]      fetch_data;
	input  wire logic [`RAS_AXI_AW-1:0] s_axi_awaddr;
	input  wire logic                   s_axi_awvalid;
	output logic                        s_axi_awready;
	input  wire logic [31:0]            s_axi_wdata;
	input  wire logic [3:0]             s_axi_wstrb;
	input  wire logic                   s_axi_wvalid;
	output logic                        s_axi_wready;
	output logic [1:0]                  s_axi_bresp;
	output logic                        s_axi_bvalid;
	input  wire logic                   s_axi_bready;
	input  wire logic [`RAS_AXI_AW-1:0] s_axi_araddr;
	input  wire logic                   s_axi_arvalid;
	output logic                        s_axi_arready;
	output logic [31:0]                 s_axi_rdata;
	output logic [1:0]                  s_axi_rresp;
	output logic                        s_axi_rvalid;
	input  wire logic                   s_axi_rready;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// Pointer width is fixed at five bits, so the depth must fill it
	if (DEPTH != (1 << `RAS_SP_W) - 1) begin : g_bad_depth
		$error("DEPTH must be 2**SP_W - 1");
	end
	// A full-size memory would leave no space to gate, and the limit wraps
	if (IMPL_BYTES < 2 || IMPL_BYTES >= (1 << `RAS_PC_W) ||
	    (IMPL_BYTES & (IMPL_BYTES - 1)) != 0) begin : g_bad_impl
		$error("IMPL_BYTES must be a power of two within the space");
	end

	localparam logic [`RAS_SP_W-1:0] SP_TOP  = `RAS_SP_W'(DEPTH);
	localparam logic [`RAS_SP_W-1:0] SP_LAST = `RAS_SP_W'(DEPTH - 1);
	localparam logic [`RAS_PC_W-1:0] IMPL_LIM = `RAS_PC_W'(IMPL_BYTES);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [`RAS_PC_W-1:0] stk_mem [1:DEPTH]; // No entry behind zero
	ras_ptr_t             ptr_r, ptr_nxt;    // Pointer register
	logic                 ld_v_r, ld_v_nxt;  // Program counter load
	logic [`RAS_PC_W-1:0] ld_pc_r, ld_pc_nxt;
	logic                 drq_r, drq_nxt;    // Device reset request
	logic                 boot_r, boot_nxt;  // First cycle after reset
	logic                 mem_we;            // Stack entry write
	logic [`RAS_SP_W-1:0] mem_idx;
	logic [`RAS_PC_W-1:0] mem_wd;
	logic                 push_any;          // Any saving request
	logic [`RAS_PC_W-1:0] top_val;           // Entry under pointer

	// AXI write and read channel state
	logic                   aw_h_r, aw_h_nxt;  // Address held
	logic [`RAS_AXI_AW-1:0] aw_a_r, aw_a_nxt;
	logic                   w_h_r, w_h_nxt;    // Data held
	logic [7:0]             w_d_r, w_d_nxt;    // Only low byte used
	logic                   w_s_r, w_s_nxt;    // Low lane strobe
	logic                   awr_r, awr_nxt;
	logic                   wr_r, wr_nxt;
	logic                   bv_r, bv_nxt;
	logic [1:0]             br_r, br_nxt;
	logic                   arr_r, arr_nxt;
	logic                   rv_r, rv_nxt;
	logic [1:0]             rr_r, rr_nxt;
	logic [31:0]            rd_r, rd_nxt;
	logic                   wr_go;             // Write performed now
	ras_reg_t               wsel, rsel;

	// Fetch pipeline
	logic                   f1_r, f1_nxt;      // Address issued
	logic                   in_r, in_nxt;      // Inside memory
	logic [MA_W-1:0]        ma_r, ma_nxt;
	logic                   fv_r, fv_nxt;
	logic [`RAS_WORD_W-1:0] fd_r, fd_nxt;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Register decode shared by the read and write paths
	function automatic ras_reg_t reg_sel(input logic [`RAS_AXI_AW-1:0] a);
		if (a == `RAS_OFS_PTR) begin
			return ras_reg_ptr;
		end else if (a == `RAS_OFS_TOP_LO) begin
			return ras_reg_lo;
		end else if (a == `RAS_OFS_TOP_HI) begin
			return ras_reg_hi;
		end else if (a == `RAS_OFS_TOP_UP) begin
			return ras_reg_up;
		end else begin
			return ras_reg_none;
		end
	endfunction : reg_sel

	// Pointer zero has no storage, so it reads as zero
	assign top_val  = (ptr_r.sp == `RAS_SP_RST) ? '0 : stk_mem[ptr_r.sp];
	assign push_any = core_req.push | core_req.int_ack;
	assign wsel     = reg_sel(aw_a_r);
	assign rsel     = reg_sel(s_axi_araddr);
	assign wr_go    = aw_h_r & w_h_r & ~bv_r;

	// ----------------------------------------------------------------
	// Stack core
	// ----------------------------------------------------------------
	// Software flag clears go first so a hardware set in the same cycle wins
	always_comb begin
		ptr_nxt   = ptr_r;
		ld_v_nxt  = 1'b0;
		ld_pc_nxt = ld_pc_r;
		drq_nxt   = 1'b0;
		boot_nxt  = 1'b0;
		mem_we    = 1'b0;
		mem_idx   = ptr_r.sp;
		mem_wd    = core_req.pc;
		if (wr_go && w_s_r && wsel == ras_reg_ptr) begin
			// Zero clears a flag, one leaves it alone
			if (!w_d_r[`RAS_BIT_FULL]) begin
				ptr_nxt.full = 1'b0;
			end
			if (!w_d_r[`RAS_BIT_UNF]) begin
				ptr_nxt.unf = 1'b0;
			end
		end
		if (push_any) begin
			mem_we = 1'b1;
			if (ptr_r.sp >= SP_LAST) begin
				// This push fills the stack or lands beyond it
				ptr_nxt.full = 1'b1;
				mem_idx      = SP_TOP;
				if (ovf_rst_en) begin
					mem_wd     = core_req.pc + `RAS_PC_STEP;
					ptr_nxt.sp = `RAS_SP_RST;
					drq_nxt    = 1'b1;
				end else begin
					ptr_nxt.sp = SP_TOP;
				end
			end else begin
				// Increment first, write the new slot
				ptr_nxt.sp = ptr_r.sp + 5'h01;
				mem_idx    = ptr_r.sp + 5'h01;
			end
			if (core_req.int_ack) begin
				ld_v_nxt  = 1'b1;
				ld_pc_nxt = core_req.int_sel ? `RAS_VEC_B : `RAS_VEC_A;
			end
		end else if (core_req.pop) begin
			// Return value goes only to the counter, latches untouched
			ld_v_nxt  = 1'b1;
			ld_pc_nxt = top_val;
			if (ptr_r.sp == `RAS_SP_RST) begin
				ptr_nxt.unf = 1'b1;
				drq_nxt     = ovf_rst_en;
			end else begin
				ptr_nxt.sp = ptr_r.sp - 5'h01;
			end
		end else if (wr_go && w_s_r) begin
			// Software pointer value and entry edits only when no stack operation is under way
			if (wsel == ras_reg_ptr) begin
				ptr_nxt.sp = w_d_r[`RAS_SP_W-1:0];
			end else if (ptr_r.sp != `RAS_SP_RST) begin
				if (wsel == ras_reg_lo) begin
					mem_we = 1'b1;
					mem_wd = {top_val[20:8], w_d_r};
				end else if (wsel == ras_reg_hi) begin
					mem_we = 1'b1;
					mem_wd = {top_val[20:16], w_d_r, top_val[7:0]};
				end else if (wsel == ras_reg_up) begin
					mem_we = 1'b1;
					mem_wd = {w_d_r[4:0], top_val[15:0]};
				end
			end
		end
		// Any device reset clears the pointer and restarts at the vector
		if (sys_rst || boot_r) begin
			ptr_nxt.sp = `RAS_SP_RST;
			ld_v_nxt   = 1'b1;
			ld_pc_nxt  = `RAS_VEC_RESET;
		end
		ptr_nxt.rsv = 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_r   <= `RAS_PTR_RST;
			ld_v_r  <= 1'b0;
			ld_pc_r <= `RAS_VEC_RESET;
			drq_r   <= 1'b0;
			boot_r  <= 1'b1;
		end else begin
			ptr_r   <= ptr_nxt;
			ld_v_r  <= ld_v_nxt;
			ld_pc_r <= ld_pc_nxt;
			drq_r   <= drq_nxt;
			boot_r  <= boot_nxt;
		end
	end

	// Entry storage has no reset; pointer zero guards stale contents
	always_ff @(posedge clk) begin
		if (mem_we && mem_idx != `RAS_SP_RST) begin
			stk_mem[mem_idx] <= mem_wd;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	// Address and data may arrive in either order; both are held
	always_comb begin
		aw_h_nxt = aw_h_r;
		aw_a_nxt = aw_a_r;
		w_h_nxt  = w_h_r;
		w_d_nxt  = w_d_r;
		w_s_nxt  = w_s_r;
		bv_nxt   = bv_r;
		br_nxt   = br_r;
		if (s_axi_awvalid && awr_r) begin
			aw_h_nxt = 1'b1;
			aw_a_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_r) begin
			w_h_nxt = 1'b1;
			w_d_nxt = s_axi_wdata[7:0];
			w_s_nxt = s_axi_wstrb[0];
		end
		if (wr_go) begin
			// Stack only reachable through the decoded registers
			aw_h_nxt = 1'b0;
			w_h_nxt  = 1'b0;
			bv_nxt   = 1'b1;
			br_nxt   = (wsel == ras_reg_none) ? `RAS_RESP_SLVERR
			                                  : `RAS_RESP_OKAY;
		end else if (bv_r && s_axi_bready) begin
			bv_nxt = 1'b0;
		end
		awr_nxt = ~aw_h_nxt;
		wr_nxt  = ~w_h_nxt;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_h_r <= 1'b0;
			aw_a_r <= '0;
			w_h_r  <= 1'b0;
			w_d_r  <= '0;
			w_s_r  <= 1'b0;
			awr_r  <= 1'b1;
			wr_r   <= 1'b1;
			bv_r   <= 1'b0;
			br_r   <= `RAS_RESP_OKAY;
		end else begin
			aw_h_r <= aw_h_nxt;
			aw_a_r <= aw_a_nxt;
			w_h_r  <= w_h_nxt;
			w_d_r  <= w_d_nxt;
			w_s_r  <= w_s_nxt;
			awr_r  <= awr_nxt;
			wr_r   <= wr_nxt;
			bv_r   <= bv_nxt;
			br_r   <= br_nxt;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	// One read at a time; data shows state before the accepting edge
	always_comb begin
		arr_nxt = arr_r;
		rv_nxt  = rv_r;
		rr_nxt  = rr_r;
		rd_nxt  = rd_r;
		if (s_axi_arvalid && arr_r) begin
			arr_nxt = 1'b0;
			rv_nxt  = 1'b1;
			rr_nxt  = `RAS_RESP_OKAY;
			rd_nxt  = '0;
			if (rsel == ras_reg_ptr) begin
				rd_nxt[7:0] = ptr_r;
			end else if (rsel == ras_reg_lo) begin
				rd_nxt[7:0] = top_val[7:0];
			end else if (rsel == ras_reg_hi) begin
				rd_nxt[7:0] = top_val[15:8];
			end else if (rsel == ras_reg_up) begin
				rd_nxt[4:0] = top_val[20:16];
			end else begin
				rr_nxt = `RAS_RESP_SLVERR;
			end
		end else if (rv_r && s_axi_rready) begin
			rv_nxt  = 1'b0;
			arr_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arr_r <= 1'b1;
			rv_r  <= 1'b0;
			rr_r  <= `RAS_RESP_OKAY;
			rd_r  <= '0;
		end else begin
			arr_r <= arr_nxt;
			rv_r  <= rv_nxt;
			rr_r  <= rr_nxt;
			rd_r  <= rd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Program fetch port
	// ----------------------------------------------------------------
	// Own bus, so fetches run alongside register traffic
	always_comb begin
		f1_nxt = fetch_req;
		in_nxt = (fetch_addr < IMPL_LIM);
		ma_nxt = fetch_req ? fetch_addr[MA_W-1:0] : ma_r;
		fv_nxt = f1_r;
		// Unimplemented space reads as all zeros, a no-operation
		fd_nxt = f1_r ? (in_r ? mem_rdata : '0) : fd_r;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			f1_r <= 1'b0;
			in_r <= 1'b0;
			ma_r <= '0;
			fv_r <= 1'b0;
			fd_r <= '0;
		end else begin
			f1_r <= f1_nxt;
			in_r <= in_nxt;
			ma_r <= ma_nxt;
			fv_r <= fv_nxt;
			fd_r <= fd_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign pc_load_valid = ld_v_r;
	assign pc_load       = ld_pc_r;
	assign dev_reset_req = drq_r;
	assign mem_addr      = ma_r;
	assign fetch_valid   = fv_r;
	assign fetch_data    = fd_r;
	assign s_axi_awready = awr_r;
	assign s_axi_wready  = wr_r;
	assign s_axi_bvalid  = bv_r;
	assign s_axi_bresp   = br_r;
	assign s_axi_arready = arr_r;
	assign s_axi_rvalid  = rv_r;
	assign s_axi_rresp   = rr_r;
	assign s_axi_rdata   = rd_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_push_inc;
		push_any && !sys_rst && !boot_r && ptr_r.sp < SP_LAST
		|=> ptr_r.sp == $past(ptr_r.sp) + 5'h01;
	endproperty
	a_push_inc: assert property (p_push_inc)
		else $error("push did not step the pointer");

	property p_pop_load;
		core_req.pop && !push_any && !sys_rst && !boot_r &&
		ptr_r.sp != 5'h00
		|=> pc_load_valid && pc_load == $past(top_val) &&
		    ptr_r.sp == $past(ptr_r.sp) - 5'h01;
	endproperty
	a_pop_load: assert property (p_pop_load)
		else $error("pop returned wrong value or pointer");

	property p_full_ovf;
		push_any && !sys_rst && !boot_r && ptr_r.sp == SP_LAST &&
		ovf_rst_en
		|=> ptr_r.full && ptr_r.sp == 5'h00 && dev_reset_req
		    ##1 !dev_reset_req;
	endproperty
	a_full_ovf: assert property (p_full_ovf)
		else $error("overflow with reset enable misbehaved");

	property p_full_hold;
		push_any && !sys_rst && !boot_r && ptr_r.sp >= SP_LAST &&
		!ovf_rst_en
		|=> ptr_r.full && ptr_r.sp == SP_TOP && !dev_reset_req;
	endproperty
	a_full_hold: assert property (p_full_hold)
		else $error("overflow without reset enable misbehaved");

	property p_unf;
		core_req.pop && !push_any && !sys_rst && !boot_r &&
		ptr_r.sp == 5'h00
		|=> ptr_r.unf && pc_load == '0 && ptr_r.sp == 5'h00 &&
		    dev_reset_req == $past(ovf_rst_en);
	endproperty
	a_unf: assert property (p_unf)
		else $error("underflow handling wrong");

	property p_full_sticky;
		ptr_r.full && !(wr_go && w_s_r && wsel == ras_reg_ptr &&
		!w_d_r[7]) |=> ptr_r.full;
	endproperty
	a_full_sticky: assert property (p_full_sticky)
		else $error("full flag cleared without software");

	property p_reset_ptr;
		sys_rst |=> ptr_r.sp == 5'h00 && pc_load_valid &&
		            pc_load == `RAS_VEC_RESET;
	endproperty
	a_reset_ptr: assert property (p_reset_ptr)
		else $error("device reset left pointer or vector wrong");

	property p_vec;
		core_req.int_ack && !sys_rst && !boot_r
		|=> pc_load_valid &&
		    pc_load == ($past(core_req.int_sel) ? `RAS_VEC_B : `RAS_VEC_A);
	endproperty
	a_vec: assert property (p_vec)
		else $error("interrupt vector wrong");

	property p_fetch_zero;
		fetch_req && fetch_addr >= IMPL_LIM
		|-> ##2 fetch_valid && fetch_data == '0;
	endproperty
	a_fetch_zero: assert property (p_fetch_zero)
		else $error("fetch outside memory not zero");

	property p_hw_wins;
		(push_any || core_req.pop) && wr_go && wsel == ras_reg_ptr &&
		!sys_rst && !boot_r && ptr_r.sp < SP_LAST && ptr_r.sp != 5'h00
		|=> ptr_r.sp == ($past(push_any) ? $past(ptr_r.sp) + 5'h01
		                                 : $past(ptr_r.sp) - 5'h01);
	endproperty
	a_hw_wins: assert property (p_hw_wins)
		else $error("software pointer write beat stack operation");

	property p_rsv_zero;
		ptr_r.rsv == 1'b0 && ptr_r.sp <= SP_TOP;
	endproperty
	a_rsv_zero: assert property (p_rsv_zero)
		else $error("reserved pointer bit set");

endmodule : ras_top

// file: design/ras_top_unused_note.sv
// Holds no logic: all logic of the return address stack is in ras_top.sv.
// Assumes nothing of its surroundings; it declares nothing.

// file: testbench/ras_mem_model.sv
// Program memory model on the far side of the fetch port.
// Assumes a combinational read of the address the stack block drives.
`timescale 1ns/100ps

module ras_mem_model (
	mem_addr,
	mem_rdata
);
	input  wire logic [14:0] mem_addr;  // Byte address from the block
	output logic [15:0]      mem_rdata; // Never zero, so gating shows
	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Top bit set: a zero seen at the block output came from its gating
	assign mem_rdata = {1'b1, mem_addr};
endmodule : ras_mem_model

// file: testbench/tb_return_address_stack.sv
// Bench for the return address stack: AXI4-Lite and core sequences.
// Assumes the block answers on clk; sys_rst is pulsed once mid-run.
`timescale 1ns/100ps

module tb_return_address_stack
	import ras_pkg::*;
;
	logic clk = 0, arst_n = 0, ovf = 0, frq = 0, pv_ok, rs, awv = 0;
	logic srst = 0; // Device reset pulse other than power-on
	logic wv = 0, br = 0, arv = 0, rr = 0, fv, bv, rv, awr, wr, arr, dr;
	logic [20:0] fa = 0, pv, pl;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd, rdv;
	logic [1:0] rsp, brsp, rrsp;
	logic [14:0] ma;
	logic [15:0] md, fd;
	ras_core_req_t cq = '0;
	int n_fail = 0, total_checks = 0, cyc = 0, i;
	always #2.5 clk = ~clk;
	ras_top i_ras_top (.clk(clk), .arst_n(arst_n), .sys_rst(srst),
		.ovf_rst_en(ovf), .core_req(cq), .pc_load_valid(pv_ok),
		.pc_load(pl), .dev_reset_req(dr), .fetch_req(frq),
		.fetch_addr(fa), .mem_addr(ma), .mem_rdata(md),
		.fetch_valid(fv), .fetch_data(fd), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(brsp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdv), .s_axi_rresp(rrsp), .s_axi_rvalid(rv),
		.s_axi_rready(rr));
	ras_mem_model i_ras_mem_model (.mem_addr(ma), .mem_rdata(md));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] g, e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Handshakes seen at the falling edge take effect at the next rise
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		@(posedge clk) {awv, wv, br, awa, wd} <= {3'b111, a, d};
		{ta, tw} = 2'b00;
		// Each channel drops its valid at the edge that takes it
		while (!(ta && tw)) begin
			@(negedge clk) {ta, tw} = {ta || awr, tw || wr};
			@(posedge clk) {awv, wv} <= {!ta, !tw};
		end
		do @(negedge clk); while (bv !== 1'b1);
		rsp = brsp;
		@(posedge clk) br <= 0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] a);
		@(posedge clk) {arv, rr, ara} <= {2'b11, a};
		do @(negedge clk); while (arr !== 1'b1);
		@(posedge clk) arv <= 0;
		do @(negedge clk); while (rv !== 1'b1);
		{rd, rsp} = {rdv, rrsp};
		@(posedge clk) rr <= 0;
	endtask : rd_reg
	// One core pulse, then watch the program counter load and reset
	task op(input logic p, q, ia, s, input logic [20:0] pc);
		@(posedge clk) cq <= '{p, q, ia, s, pc};
		@(posedge clk) cq <= '0;
		{pv, rs} = 0;
		repeat (3) begin
			@(negedge clk);
			if (pv_ok === 1'b1) pv = pl;
			if (dr === 1'b1) rs = 1;
		end
	endtask : op
	always @(posedge clk) if (++cyc > 20000) begin
		n_fail++;
		complete_run();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		pv = 1;
		repeat (3) @(posedge clk);
		arst_n <= 1;
		repeat (2) @(negedge clk) if (pv_ok === 1'b1) pv = pl;
		chk(pv, 0);
		rd_reg(8'h00); chk(rd, 0);
		op(1, 0, 0, 0, 21'h012344);
		op(1, 0, 0, 0, 21'h1abcd6);
		rd_reg(8'h00); chk(rd, 2);
		rd_reg(8'h04); chk(rd, 8'hd6);
		rd_reg(8'h08); chk(rd, 8'hbc);
		rd_reg(8'h0c); chk(rd, 8'h1a);
		// No core pulse while the top entry is edited
		wr_reg(8'h04, 8'h10);
		chk(rsp, 0);
		op(0, 1, 0, 0, 0); chk(pv, 21'h1abc10);
		op(0, 1, 0, 0, 0); chk(pv, 21'h012344);
		op(0, 1, 0, 0, 21'h1); chk(pv, 0);
		rd_reg(8'h00); chk(rd, 8'h40);
		wr_reg(8'h00, 8'hc0); rd_reg(8'h00); chk(rd, 8'h40);
		wr_reg(8'h00, 8'h00); rd_reg(8'h00); chk(rd, 0);
		$display("end of stack basics");
		op(0, 0, 1, 1, 21'h100); chk(pv, 21'h18);
		op(0, 0, 1, 0, 21'h100); chk(pv, 21'h08);
		rd_reg(8'h00); chk(rd, 2);
		wr_reg(8'h00, 8'h00);
		for (i = 1; i <= 31; i++) op(1, 0, 0, 0, 21'(i * 2));
		rd_reg(8'h00); chk(rd, 8'h9f);
		op(1, 0, 0, 0, 21'h0000aa); chk(rs, 0);
		rd_reg(8'h00); chk(rd, 8'h9f);
		rd_reg(8'h04); chk(rd, 8'haa);
		$display("end of overflow hold");
		ovf <= 1;
		wr_reg(8'h00, 8'h1e);
		op(1, 0, 0, 0, 21'h000100); chk(rs, 1);
		rd_reg(8'h00); chk(rd, 8'h80);
		wr_reg(8'h00, 8'h9f);
		rd_reg(8'h04); chk(rd, 8'h02);
		rd_reg(8'h08); chk(rd, 8'h01);
		wr_reg(8'h00, 8'h00);
		op(0, 1, 0, 0, 0); chk(rs, 1);
		rd_reg(8'h00); chk(rd, 8'h40);
		// Pointer write lands in the same cycle as a push
		wr_reg(8'h00, 8'h45);
		fork
			wr_reg(8'h00, 8'h5f);
			begin @(posedge clk); op(1, 0, 0, 0, 21'h0000c4); end
		join
		rd_reg(8'h00); chk(rd, 8'h46);
		rd_reg(8'h04); chk(rd, 8'hc4);
		@(posedge clk) srst <= 1;
		@(posedge clk) srst <= 0;
		@(negedge clk) chk({pv_ok, pl}, 32'h200000);
		rd_reg(8'h00); chk(rd, 8'h40);
		$display("end of overflow reset");
		rd_reg(8'h10); chk(rsp, 2'b10);
		chk(rd, 0);
		wr_reg(8'h14, 8'h00); chk(rsp, 2'b10);
		for (i = 0; i < 2; i++) begin
			@(posedge clk) {frq, fa} <= {1'b1, i ? 21'h008000 : 21'h6};
			@(posedge clk) frq <= 0;
			repeat (3) @(negedge clk) if (fv === 1'b1) rd = fd;
			chk(rd, i ? 0 : 16'h8006);
		end
		$display("end of bus and fetch");
		complete_run();
	end
endmodule : tb_return_address_stack
